// *** bench/ext_bus_ctrl_assertions.sv ***
// Port-level checks for the external bus controller
`timescale 1ns/1ns
module ext_bus_ctrl_assertions #(
  parameter AW = 20
) (
  // Clock, reset and inputs
  input wire clk_sys_in,
  input wire rst_in,
  input wire strobe_style_sel_in,
  input wire bus_takeover_req_n_in,
  // Bus pins
  input wire [AW-1:0] addr_out,
  input wire addr_oe_out,
  input wire data_oe_out,
  input wire ctl_oe_out,
  input wire [3:0] chip_select_n_out,
  input wire read_strobe_n_out,
  input wire write_strobe_n_out,
  input wire byte_high_enable_n_out,
  input wire addr_latch_enable_out,
  input wire bus_grant_ack_n_out,
  // Ports and peripherals
  input wire [4:0] port_low_oe_out,
  input wire [4:0] port_high_val_out,
  input wire watchdog_run_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire idle = &chip_select_n_out;
  wire ack = !bus_grant_ack_n_out;
  // ----------------------------------------
  // Steps of an access and of a takeover
  // ----------------------------------------
  sequence strobe_start;
    $fell(read_strobe_n_out) || $fell(write_strobe_n_out);
  endsequence
  // Synchroniser delay means a fresh request edge is not yet seen
  sequence hold_held;
    (!bus_takeover_req_n_in)[*3] ##0 ack;
  endsequence
  idle_strobes_a: assert property (idle && !ack |-> read_strobe_n_out && write_strobe_n_out
    && (byte_high_enable_n_out || !strobe_style_sel_in)) else $error("strobe low while idle");
  split_read_a: assert property (strobe_style_sel_in && !read_strobe_n_out
    |-> write_strobe_n_out && byte_high_enable_n_out) else $error("split read not alone");
  read_alone_a: assert property (!read_strobe_n_out |-> write_strobe_n_out)
    else $error("read and write strobes together");
  strobe_len_a: assert property (strobe_start |=>
    !(read_strobe_n_out && write_strobe_n_out) && $stable(addr_out)) else $error("strobe cut short");
  ale_fall_a: assert property ($rose(addr_latch_enable_out) |->
    $stable(addr_out) ##1 !addr_latch_enable_out) else $error("latch enable misplaced");
  hold_float_a: assert property (ack |-> !addr_oe_out && !data_oe_out && !ctl_oe_out)
    else $error("bus driven in hold");
  hold_ports_a: assert property (ack |-> port_low_oe_out == 5'h00 && !watchdog_run_out)
    else $error("ports or watchdog active in hold");
  hold_freeze_a: assert property (ack && $past(ack) |-> $stable(port_high_val_out))
    else $error("held port changed");
  hold_entry_a: assert property ($fell(bus_grant_ack_n_out) |-> $past(idle))
    else $error("hold cut an access");
  hold_release_a: assert property (bus_takeover_req_n_in[*5] |-> !ack)
    else $error("ack without request");
  hold_keep_a: assert property (hold_held |=> ack) else $error("hold dropped early");
endmodule
bind ext_bus_ctrl ext_bus_ctrl_assertions #(.AW(AW)) i_ext_bus_ctrl_assertions (.clk_sys_in,
  .rst_in, .strobe_style_sel_in, .bus_takeover_req_n_in, .addr_out, .addr_oe_out, .data_oe_out,
  .ctl_oe_out, .chip_select_n_out, .read_strobe_n_out, .write_strobe_n_out,
  .byte_high_enable_n_out, .addr_latch_enable_out, .bus_grant_ack_n_out, .port_low_oe_out,
  .port_high_val_out, .watchdog_run_out);

// *** bench/ext_bus_partner.sv ***
// Model of slow external memory and an outside bus master
`timescale 1ns/1ns
module ext_bus_partner (
  // Clock, reset and scenario controls
  input wire clk_sys_in,
  input wire rst_in,
  input wire hold_req,
  input wire [3:0] wait_n,
  // Bus pins seen from the far side
  input wire [19:0] addr_out,
  input wire [3:0] chip_select_n_out,
  input wire read_strobe_n_out,
  input wire addr_latch_enable_out,
  output logic ready_in_n_in,
  output logic bus_takeover_req_n_in,
  output logic [15:0] data_in
);
  logic [19:0] a_q, lat_a;
  logic ale_q, use_lat;
  logic [3:0] k;
  wire fall = ale_q && !addr_latch_enable_out;
  wire [19:0] ea = fall ? a_q : (use_lat ? lat_a : addr_out);
  // Answers move on the falling edge, clear of the design's sampling edge
  always @(negedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      {ready_in_n_in, bus_takeover_req_n_in, ale_q, use_lat, k} <= 8'hc0;
      data_in <= 16'h0000;
    end else begin
      bus_takeover_req_n_in <= ~hold_req;
      ale_q <= addr_latch_enable_out;
      a_q <= addr_out;
      if (fall) lat_a <= a_q;
      use_lat <= !(&chip_select_n_out) && (use_lat || fall);
      k <= (&chip_select_n_out) ? 4'h0 : k + {3'h0, k != 4'hf};
      // Slow device parks ready low between selects, so the request clears
      // the two-flop input synchroniser before the wait sample point
      ready_in_n_in <= (&chip_select_n_out) ? (wait_n == 4'h0) : (k >= wait_n);
      // Released lines toggle so a stale value never passes for read data
      data_in <= !read_strobe_n_out ? {8'h3c, ea[7:0]} : ~data_in;
    end
  end
endmodule

// *** bench/test_ext_bus_ctrl.sv ***
// Self-checking bench for the external bus controller
`timescale 1ns/1ns
module test_ext_bus_ctrl;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  // Row fields: 8-bit, style, write, word, area, addr, low strobes rd/wr/bhe, bhe checked
  typedef struct packed {logic w8, st, wr, sz; logic [1:0] ar; logic [3:0] a;
    logic [2:0] e; logic m;} row_t;
  row_t rows [10] = '{14'h2036, 14'h282a, 14'h1407, 14'h182b, 14'h183d, 14'h1c49,
    14'h0015, 14'h0027, 14'h0c69, 14'h05a5};
  row_t r;
  logic clk_sys_in = 0, rst_in = 1, width_select_pin_in = 1, strobe_style_sel_in = 0;
  logic hold_req = 0, cpu_valid_in = 0, cpu_write_in = 0, cpu_size_in = 0;
  logic dma_valid_in = 0, dma_write_in = 0, dma_size_in = 0;
  logic [1:0] cpu_area_in = 2'h0, dma_area_in = 2'h0;
  logic [3:0] area_wait_enable_in = 4'hf, area_mux_in = 4'h2, wait_n = 4'h0;
  logic [19:0] cpu_addr_in = 20'h0, dma_addr_in = 20'h0;
  logic [15:0] cpu_wdata_in = 16'ha55a, dma_wdata_in = 16'h5aa5;
  logic [4:0] port_high_val_in = 5'h0a;
  wire cpu_ready_out, dma_ready_out, done_out, addr_oe_out, data_oe_out, ctl_oe_out;
  wire read_strobe_n_out, write_strobe_n_out, byte_high_enable_n_out, addr_latch_enable_out;
  wire ready_in_n_in, bus_takeover_req_n_in, bus_grant_ack_n_out, watchdog_run_out;
  wire [19:0] addr_out;
  wire bus_clock_out;
  wire [15:0] rdata_out, data_in, data_out;
  wire [3:0] chip_select_n_out;
  wire [4:0] port_low_oe_out, port_high_val_out;
  int miscompares = 0, samples_checked = 0, cnt = 0, lats = 0, b;
  logic [2:0] lo = 3'h7, sp = 3'h7;
  logic [3:0] adq [$];
  // Byte-high enable counts as a strobe only in the split-write style
  wire [2:0] s3 = {read_strobe_n_out, write_strobe_n_out,
    byte_high_enable_n_out | ~strobe_style_sel_in};
  ext_bus_ctrl i_ext_bus_ctrl (.clk_sys_in, .rst_in, .width_select_pin_in, .strobe_style_sel_in,
    .bus_clock_out_disable_in(1'b0), .area_wait_enable_in, .area_mux_in, .cpu_valid_in,
    .cpu_ready_out, .cpu_write_in, .cpu_size_in, .cpu_area_in, .cpu_addr_in, .cpu_wdata_in,
    .dma_valid_in, .dma_ready_out, .dma_write_in, .dma_size_in, .dma_area_in, .dma_addr_in,
    .dma_wdata_in, .done_out, .rdata_out, .bus_clock_out, .addr_out, .addr_oe_out,
    .data_out, .data_oe_out, .data_in, .chip_select_n_out, .read_strobe_n_out,
    .write_strobe_n_out, .byte_high_enable_n_out, .ctl_oe_out, .addr_latch_enable_out,
    .ready_in_n_in, .bus_takeover_req_n_in, .bus_grant_ack_n_out, .port_low_oe_in(5'h1f),
    .port_low_oe_out, .port_high_oe_in(5'h1f), .port_high_val_in, .port_high_oe_out(),
    .port_high_val_out, .watchdog_run_out);
  ext_bus_partner i_ext_bus_partner (.clk_sys_in, .rst_in, .hold_req, .wait_n, .addr_out,
    .chip_select_n_out, .read_strobe_n_out, .addr_latch_enable_out, .ready_in_n_in,
    .bus_takeover_req_n_in, .data_in);
  always #2 clk_sys_in = ~clk_sys_in;
  // Record address, lowest strobe levels and length of each access
  always @(negedge clk_sys_in) begin
    if (sp == 3'h7 && s3 != 3'h7) begin
      adq.push_back(addr_out[3:0]);
      lo = 3'h7;
      cnt = 0;
    end
    if (s3 != 3'h7) lo = lo & {read_strobe_n_out, write_strobe_n_out, byte_high_enable_n_out};
    cnt++;
    if (done_out === 1'b1) lats = cnt;
    sp = s3;
  end
  // ----------------------------------------
  // Drivers and waits
  // ----------------------------------------
  task cpu(input logic w, input logic s, input logic [19:0] a);
    @(negedge clk_sys_in);
    {cpu_valid_in, cpu_write_in, cpu_size_in, cpu_addr_in} = {1'b1, w, s, a};
    while (cpu_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    cpu_valid_in = 0;
  endtask
  task dma(input logic [19:0] a);
    @(negedge clk_sys_in);
    {dma_valid_in, dma_write_in, dma_addr_in} = {1'b1, 1'b1, a};
    while (dma_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    dma_valid_in = 0;
  endtask
  task wd;
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 300) miscompares++;
    @(negedge clk_sys_in);
  endtask
  task wait_ack(input logic v);
    int n;
    n = 0;
    while (bus_grant_ack_n_out !== v && n < 50) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("grant ack", v, bus_grant_ack_n_out)
  endtask
  task do_reset;
    rst_in = 1;
    repeat (20) @(negedge clk_sys_in);
    rst_in = 0;
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Generous ceiling, far past the expected run of a few hundred cycles
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    do_reset;
    `CHK("idle strobes", 3'h7, {read_strobe_n_out, write_strobe_n_out, byte_high_enable_n_out})
    foreach (rows[i]) begin
      r = rows[i];
      // Width is only changed under reset, never in operation
      if (r.w8 !== width_select_pin_in) begin
        width_select_pin_in = r.w8;
        do_reset;
      end
      strobe_style_sel_in = r.st;
      cpu_area_in = r.ar;
      cpu(r.wr, r.sz, {16'h0, r.a});
      wd;
      `CHK("strobe set", r.e | {2'h0, ~r.m}, lo | {2'h0, ~r.m})
      if (!r.wr && r.sz && r.ar == 2'h0) `CHK("read data", {12'h3c0, r.a}, rdata_out)
      if (r.wr && r.sz) `CHK("write data", cpu_wdata_in, data_out)
    end
    // Bus clock follows the system clock in both phases
    @(posedge clk_sys_in) #1;
    `CHK("bus clock high", 1'b1, bus_clock_out)
    @(negedge clk_sys_in) #1;
    `CHK("bus clock low", 1'b0, bus_clock_out)
    @(negedge clk_sys_in);
    // Ready requests count only where the area asks for waits
    cpu_area_in = 2'h0;
    cpu(1'b0, 1'b1, 20'h0);
    wd;
    b = lats;
    wait_n = 4'h6;
    cpu(1'b0, 1'b1, 20'h0);
    wd;
    `CHK("ignored ready", b, lats)
    area_wait_enable_in = 4'he;
    cpu(1'b0, 1'b1, 20'h0);
    wd;
    `CHK("ready wait", 1'b1, lats > b)
    // Takeover requested in the middle of a stretched access
    fork
      cpu(1'b0, 1'b1, 20'h10);
      begin
        repeat (3) @(negedge clk_sys_in);
        hold_req = 1;
      end
    join
    wd;
    wait_ack(1'b0);
    `CHK("hold pins", 8'h00, {watchdog_run_out, port_low_oe_out, addr_oe_out, data_oe_out})
    port_high_val_in = 5'h15;
    repeat (3) @(negedge clk_sys_in);
    `CHK("frozen port", 5'h0a, port_high_val_out)
    // CPU and DMA both queued behind the hold
    cpu(1'b1, 1'b1, 20'h4);
    fork
      dma(20'h8);
    join_none
    repeat (4) @(negedge clk_sys_in);
    adq.delete();
    hold_req = 0;
    wd;
    wd;
    wait_ack(1'b1);
    `CHK("first owner", 4'h8, adq[0])
    // DMA arrives during the first half of an odd-address word
    adq.delete();
    strobe_style_sel_in = 1;
    fork
      cpu(1'b1, 1'b1, 20'h5);
    join_none
    while (adq.size() == 0) @(negedge clk_sys_in);
    fork
      dma(20'h2);
    join_none
    wd;
    wd;
    `CHK("odd word order", 12'h562, {adq[0], adq[1], adq[2]})
    close_out;
  end
endmodule

// *** verilog/bus_fifo.v ***
// Request FIFO with parameterised width and depth
`timescale 1ns/1ns
module bus_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_q];

  // Storage array, no reset needed on data
  always @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers wrap naturally only when depth is a power of two
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** verilog/ext_bus_ctrl.v ***
// External bus controller: strobes, address latch, ready waits, hold and priority
//
// Contract
// - 16-bit bus picks byte-enable or split-write strobe set by style select.
// - 8-bit bus uses read and write strobes only; byte-high enable unused.
// - Split-write: read strobe alone reads; low/high/both write strobes per byte.
// - Byte-enable style: byte-high enable and address bit 0 select bytes.
// - Multiplexed area accesses present the address with address latch enable.
// - Ready low at last bus clock falling edge inserts one wait state.
// - During ready wait, all bus outputs hold their accepted levels.
// - Ready sampled high at a falling edge lets the cycle finish.
// - Ready honoured only when the area wait enable bit is zero.
// - Takeover request enters hold only after the current access completes.
// - Hold lasts while takeover request low; grant acknowledge low throughout.
// - Priority is outside takeover, then DMA, then CPU.
// - DMA cannot cut between the two halves of an odd-address word.
// - In hold, bus floats, bus clock runs, latch enable undefined, ack low.
// - Hold floats port groups 0,1,3,4; groups 6 to 10 keep levels.
// - Peripherals run in hold but the watchdog is paused.
// - Width pin high gives 8-line bus, low 16-line; fixed in operation.
// - Bus clock disable zero outputs bus clock at CPU clock frequency.
`timescale 1ns/1ns
`include "ext_bus_defs.vh"
module ext_bus_ctrl #(
  parameter AW = 20,
  parameter DW = 16,
  parameter DEPTH = `FIFO_DEPTH,
  parameter FAW = `FIFO_AW
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Configuration
  input wire width_select_pin_in,
  input wire strobe_style_sel_in,
  input wire bus_clock_out_disable_in,
  input wire [3:0] area_wait_enable_in,
  input wire [3:0] area_mux_in,
  // CPU request side (stream into FIFO)
  input wire cpu_valid_in,
  output wire cpu_ready_out,
  input wire cpu_write_in,
  input wire cpu_size_in,
  input wire [1:0] cpu_area_in,
  input wire [AW-1:0] cpu_addr_in,
  input wire [DW-1:0] cpu_wdata_in,
  // DMA request side
  input wire dma_valid_in,
  output wire dma_ready_out,
  input wire dma_write_in,
  input wire dma_size_in,
  input wire [1:0] dma_area_in,
  input wire [AW-1:0] dma_addr_in,
  input wire [DW-1:0] dma_wdata_in,
  // Completion
  output reg done_out,
  output reg [DW-1:0] rdata_out,
  // External bus pins
  output wire bus_clock_out,
  output reg [AW-1:0] addr_out,
  output wire addr_oe_out,
  output reg [DW-1:0] data_out,
  output wire data_oe_out,
  input wire [DW-1:0] data_in,
  output reg [3:0] chip_select_n_out,
  output reg read_strobe_n_out,
  output reg write_strobe_n_out,
  output reg byte_high_enable_n_out,
  output wire ctl_oe_out,
  output reg addr_latch_enable_out,
  input wire ready_in_n_in,
  input wire bus_takeover_req_n_in,
  output reg bus_grant_ack_n_out,
  // Port groups and peripherals
  input wire [4:0] port_low_oe_in,
  output wire [4:0] port_low_oe_out,
  input wire [4:0] port_high_oe_in,
  input wire [4:0] port_high_val_in,
  output reg [4:0] port_high_oe_out,
  output reg [4:0] port_high_val_out,
  output wire watchdog_run_out
);
  localparam RW = 1 + 1 + 2 + AW + DW;
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_STRB = 6'h04;
  localparam ST_WAIT = 6'h08;
  localparam ST_END = 6'h10;
  localparam ST_HOLD = 6'h20;

  // Write low/high strobe aliases share pins with write and byte-high
  wire write_low_strobe_n_out;
  wire write_high_strobe_n_out;
  assign write_low_strobe_n_out = write_strobe_n_out;
  assign write_high_strobe_n_out = byte_high_enable_n_out;

  // Synchronised external inputs
  reg rdy_s1_q, rdy_s2_q, hold_s1_q, hold_s2_q;
  reg [DW-1:0] din_s1_q, din_s2_q;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
      hold_s1_q <= 1'b1;
      hold_s2_q <= 1'b1;
      din_s1_q <= `DATA_RESET;
      din_s2_q <= `DATA_RESET;
    end else begin
      rdy_s1_q <= ready_in_n_in;
      rdy_s2_q <= rdy_s1_q;
      hold_s1_q <= bus_takeover_req_n_in;
      hold_s2_q <= hold_s1_q;
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // CPU requests pass through the FIFO, which stalls the CPU when full
  wire fifo_valid;
  wire fifo_pop;
  wire [RW-1:0] fifo_data;
  bus_fifo #(.WIDTH(RW), .DEPTH(DEPTH), .AW(FAW)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(cpu_valid_in),
    .in_ready_out(cpu_ready_out),
    .in_data_in({cpu_write_in, cpu_size_in, cpu_area_in, cpu_addr_in, cpu_wdata_in}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  reg [5:0] state_q;
  reg [1:0] owner_q;
  reg wr_q, size_q, split_q, second_q, mux_q, waitok_q;
  reg [1:0] area_q;
  reg [DW-1:0] wdata_q;
  reg fin_q;

  // Fixed priority; DMA blocked while an odd word is half done
  wire ext_req = !hold_s2_q;
  wire at_idle = (state_q == ST_IDLE);
  wire pick_dma = at_idle && !ext_req && !second_q && dma_valid_in;
  wire pick_cpu = at_idle && !ext_req && !pick_dma && fifo_valid && !second_q;
  assign dma_ready_out = pick_dma;
  assign fifo_pop = pick_cpu;
  wire byte_bus = (width_select_pin_in == `WIDTH_SEL_8BIT);

  // Byte lane strobe decode from size and address bit 0
  function [1:0] lanes;
    input sz;
    input a0;
    input bb;
    begin
      if (bb) begin
        lanes = 2'b01;
      end else if (sz == `SIZE_WORD) begin
        lanes = 2'b11;
      end else begin
        lanes = a0 ? 2'b10 : 2'b01;
      end
    end
  endfunction

  wire [1:0] ln = lanes(size_q, addr_out[0], byte_bus);
  wire in_hold = (state_q == ST_HOLD);

  // Bus cycle sequencer
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      owner_q <= `OWN_CPU;
      wr_q <= 1'b0;
      size_q <= `SIZE_BYTE;
      split_q <= 1'b0;
      second_q <= 1'b0;
      mux_q <= 1'b0;
      waitok_q <= 1'b0;
      area_q <= 2'h0;
      wdata_q <= `DATA_RESET;
      addr_out <= `ADDR_RESET;
      data_out <= `DATA_RESET;
      chip_select_n_out <= 4'hf;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      byte_high_enable_n_out <= 1'b1;
      addr_latch_enable_out <= 1'b0;
      bus_grant_ack_n_out <= 1'b1;
      done_out <= 1'b0;
      fin_q <= 1'b0;
      rdata_out <= `DATA_RESET;
    end else begin
      // Data pins pass two flops, so read data is taken one cycle after the
      // strobe phase; done waits for it so data and done arrive together
      done_out <= fin_q;
      fin_q <= 1'b0;
      if (fin_q && !wr_q) begin
        rdata_out <= din_s2_q;
      end
      case (state_q)
        ST_IDLE: begin
          read_strobe_n_out <= 1'b1;
          write_strobe_n_out <= 1'b1;
          byte_high_enable_n_out <= 1'b1;
          if (ext_req) begin
            state_q <= ST_HOLD;
            owner_q <= `OWN_EXT;
            bus_grant_ack_n_out <= 1'b0;
            chip_select_n_out <= 4'hf;
          end else if (pick_dma || pick_cpu || second_q) begin
            state_q <= ST_ADDR;
            if (second_q) begin
              // Upper byte of an odd word goes to the next even address
              addr_out <= addr_out + 1'b1;
              size_q <= `SIZE_BYTE;
              data_out <= {8'h00, wdata_q[15:8]};
              second_q <= 1'b0;
            end else begin
              owner_q <= pick_dma ? `OWN_DMA : `OWN_CPU;
              wr_q <= pick_dma ? dma_write_in : fifo_data[RW-1];
              area_q <= pick_dma ? dma_area_in : fifo_data[RW-3:RW-4];
              addr_out <= pick_dma ? dma_addr_in : fifo_data[AW+DW-1:DW];
              wdata_q <= pick_dma ? dma_wdata_in : fifo_data[DW-1:0];
              data_out <= pick_dma ? dma_wdata_in : fifo_data[DW-1:0];
              size_q <= pick_dma ? dma_size_in : fifo_data[RW-2];
              // Odd word splits into two byte accesses
              split_q <= (pick_dma ? dma_size_in : fifo_data[RW-2]) &&
                         (pick_dma ? dma_addr_in[0] : fifo_data[DW]);
            end
          end
        end
        ST_ADDR: begin
          chip_select_n_out <= ~(4'h1 << area_q);
          mux_q <= area_mux_in[area_q];
          waitok_q <= (area_wait_enable_in[area_q] == `AREA_WAIT_ON);
          addr_latch_enable_out <= area_mux_in[area_q];
          if (split_q && !second_q && size_q == `SIZE_WORD) begin
            size_q <= `SIZE_BYTE;
          end
          state_q <= ST_STRB;
        end
        ST_STRB: begin
          addr_latch_enable_out <= 1'b0;
          if (!wr_q) begin
            read_strobe_n_out <= 1'b0;
            write_strobe_n_out <= 1'b1;
            byte_high_enable_n_out <= byte_bus ? 1'b1 :
              (strobe_style_sel_in == `STYLE_SPLIT_WRITE) ? 1'b1 : ~ln[1];
          end else if (strobe_style_sel_in == `STYLE_SPLIT_WRITE && !byte_bus) begin
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= ~ln[0];
            byte_high_enable_n_out <= ~ln[1];
          end else begin
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b0;
            byte_high_enable_n_out <= byte_bus ? 1'b1 : ~ln[1];
          end
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Last sample point of the cycle; outputs left untouched here
          if (!(waitok_q && !rdy_s2_q)) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          read_strobe_n_out <= 1'b1;
          write_strobe_n_out <= 1'b1;
          byte_high_enable_n_out <= 1'b1;
          chip_select_n_out <= 4'hf;
          if (split_q && !second_q && size_q == `SIZE_BYTE && addr_out[0]) begin
            second_q <= 1'b1;
          end else begin
            fin_q <= 1'b1;
            split_q <= 1'b0;
          end
          state_q <= ST_IDLE;
        end
        ST_HOLD: begin
          if (!ext_req) begin
            state_q <= ST_IDLE;
            bus_grant_ack_n_out <= 1'b1;
            owner_q <= `OWN_CPU;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Bus clock follows the CPU clock when enabled
  reg bclk_q;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= (bus_clock_out_disable_in == `BUS_CLK_ENABLED);
    end
  end
  assign bus_clock_out = bclk_q & clk_sys_in;

  // Float bus in hold; drive data only on writes
  assign addr_oe_out = !in_hold;
  assign ctl_oe_out = !in_hold;
  assign data_oe_out = !in_hold && wr_q && (state_q != ST_IDLE);

  // Port groups 0,1,3,4 float; groups 6 to 10 freeze at hold acceptance
  assign port_low_oe_out = in_hold ? 5'h00 : port_low_oe_in;
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      port_high_oe_out <= 5'h00;
      port_high_val_out <= 5'h00;
    end else if (!in_hold) begin
      port_high_oe_out <= port_high_oe_in;
      port_high_val_out <= port_high_val_in;
    end
  end

  // Watchdog paused in hold; other peripherals keep running
  assign watchdog_run_out = !in_hold;
endmodule

// *** verilog/ext_bus_defs.vh ***
// Constants for the external bus strobe, wait and hold controller
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
// Data width select pin level for an 8-line bus
`define WIDTH_SEL_8BIT 1'b1
// Strobe style select: 0 byte-enable style, 1 split-write style
`define STYLE_BYTE_ENABLE 1'b0
`define STYLE_SPLIT_WRITE 1'b1
// Area wait enable bit level meaning "with wait state"
`define AREA_WAIT_ON 1'b0
// Bus clock output enable level of the disable bit
`define BUS_CLK_ENABLED 1'b0
// Access size codes
`define SIZE_BYTE 1'b0
`define SIZE_WORD 1'b1
// Bus owners
`define OWN_CPU 2'h0
`define OWN_DMA 2'h1
`define OWN_EXT 2'h2
// Buffer defaults
`define FIFO_DEPTH 32
`define FIFO_AW 5
// Reset levels
`define ADDR_RESET 20'h00000
`define DATA_RESET 16'h0000
`endif
